// File: src/mac_hash_filter_phy_mgmt_regs.sv
// Purpose: APB register bank holding the 64-bit group hash table and the PHY management access pair.
// Assumes: PHY register port answers every request with a one-cycle done pulse; filter inputs share the clock.
// Notes:   Zero-wait APB slave; read data is captured in the setup cycle and presented in the access cycle.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// - Destination address hashes into multicast table
// - Table is 64 bits, high and low words
// - Index top bit picks word, rest bit
// - Index zero is low bit 0, top high 31
// - Selected bit one accepts, zero rejects
// - Pass-all bit accepts every group frame
// - First wire byte is most significant
// - Bits 10-6 pick PHY register
// - Direction one writes PHY, zero reads
// - Busy written one starts; none otherwise
// - Busy stays set until access completes
// - Read data loaded before busy clears
// - Data register holds 16 bits 15-0
module mac_hash_filter_phy_mgmt_regs
    import mac_filt_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [mac_filt_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Receive filter
    input wire logic i_da_valid,
    input wire logic [mac_filt_pkg::DA_W-1:0] i_da,
    output logic o_filter_done,
    output logic o_filter_group,
    output logic o_filter_accept,
    // PHY register port
    output logic o_phy_req,
    output mac_filt_pkg::phy_cmd_s o_phy_cmd,
    input wire logic i_phy_done,
    input wire logic [mac_filt_pkg::MGMT_DATA_W-1:0] i_phy_rdata
);
    import mac_filt_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] hash_high_ff; // Upper table word
    logic [31:0] hash_low_ff; // Lower table word
    logic pass_all_ff; // pass_all_group_frames
    logic [FIELD5_W-1:0] acc_phy_addr_ff; // Stored as written
    logic [FIELD5_W-1:0] acc_reg_ff; // phy_reg_index
    logic acc_dir_ff; // phy_access_direction
    logic [MGMT_DATA_W-1:0] mgmt_data_ff; // Write source or read result
    mgmt_state_e state_ff; // Busy flag lives here
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic filter_done_ff;
    logic filter_group_ff;
    logic filter_accept_ff;
    phy_cmd_s phy_cmd_ff;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup_ph = i_psel & ~i_penable; // Read data captured here
    wire access_ph = i_psel & i_penable; // Write commits here
    wire do_write = access_ph & i_pwrite;
    wire hit_high = (i_paddr == HASH_HIGH_ADDR);
    wire hit_low = (i_paddr == HASH_LOW_ADDR);
    wire hit_acc = (i_paddr == MGMT_ACCESS_ADDR);
    wire hit_data = (i_paddr == MGMT_DATA_ADDR);
    wire hit_ctrl = (i_paddr == FILTER_CTRL_ADDR);
    wire hit_any = hit_high | hit_low | hit_acc | hit_data | hit_ctrl;
    wire phy_busy = (state_ff == MGMT_BUSY); // phy_access_busy
    // Strobe-merged write image, applied per register
    wire [31:0] strb_mask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
    wire [31:0] wr_high = (hash_high_ff & ~strb_mask) | (i_pwdata & strb_mask);
    wire [31:0] wr_low = (hash_low_ff & ~strb_mask) | (i_pwdata & strb_mask);
    wire [31:0] acc_image = {16'h0000, acc_phy_addr_ff, acc_reg_ff, 4'h0, acc_dir_ff, phy_busy};
    wire [31:0] wr_acc = (acc_image & ~strb_mask) | (i_pwdata & strb_mask);
    wire [31:0] data_image = {16'h0000, mgmt_data_ff};
    wire [31:0] wr_data = (data_image & ~strb_mask) | (i_pwdata & strb_mask);
    // Access and data writes are dropped while a cycle runs, so the request never changes under the PHY
    wire acc_write = do_write & hit_acc & ~phy_busy;
    wire data_write = do_write & hit_data & ~phy_busy;
    wire start_cycle = acc_write & wr_acc[ACC_BUSY_BIT];
    wire cycle_end = phy_busy & i_phy_done;

    // Read mux; reserved positions are zero in the images
    wire [31:0] rd_value = hit_high ? hash_high_ff :
                           hit_low ? hash_low_ff :
                           hit_acc ? acc_image :
                           hit_data ? data_image :
                           hit_ctrl ? {31'h0000_0000, pass_all_ff} : 32'h0000_0000;

    // Zero-wait slave
    assign o_pready = 1'b1;
    assign o_prdata = prdata_ff;
    assign o_pslverr = pslverr_ff;

    // Capture read data and error in the setup cycle
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (setup_ph) begin
            prdata_ff <= i_pwrite ? 32'h0000_0000 : rd_value;
            pslverr_ff <= ~hit_any;
        end
    end

    // ------------------------------------------------------------
    // Hash table and filter control
    // ------------------------------------------------------------
    // Table words and pass-all bit
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hash_high_ff <= HASH_HIGH_RST;
            hash_low_ff <= HASH_LOW_RST;
            pass_all_ff <= FILTER_CTRL_RST;
        end else begin
            if (do_write & hit_high) begin
                hash_high_ff <= wr_high;
            end
            if (do_write & hit_low) begin
                hash_low_ff <= wr_low;
            end
            if (do_write & hit_ctrl & i_pstrb[0]) begin
                pass_all_ff <= i_pwdata[CTRL_PASS_ALL_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Group frame filter
    // ------------------------------------------------------------
    logic [HASH_IDX_W-1:0] hash_idx; // Index of the offered address

    crc_hash_index #(
        .IDX_W(HASH_IDX_W)
    ) u_hash (
        .i_da(i_da),
        .o_index(hash_idx)
    );

    // Top index bit picks the word, low five bits the bit in it
    wire [31:0] sel_word = hash_idx[HASH_IDX_W-1] ? hash_high_ff : hash_low_ff;
    wire table_bit = sel_word[hash_idx[HASH_IDX_W-2:0]];
    wire is_group = i_da[GROUP_BIT];
    wire nxt_accept = is_group & (pass_all_ff | table_bit);

    // One-cycle verdict after each offered address
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            filter_done_ff <= 1'b0;
            filter_group_ff <= 1'b0;
            filter_accept_ff <= 1'b0;
        end else begin
            filter_done_ff <= i_da_valid;
            if (i_da_valid) begin
                filter_group_ff <= is_group;
                filter_accept_ff <= nxt_accept;
            end
        end
    end

    assign o_filter_done = filter_done_ff;
    assign o_filter_group = filter_group_ff;
    assign o_filter_accept = filter_accept_ff;

    // ------------------------------------------------------------
    // PHY management engine
    // ------------------------------------------------------------
    // Access fields; loaded when idle writes land, frozen while busy
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_phy_addr_ff <= MGMT_ACCESS_RST[ACC_PHY_ADDR_LSB +: FIELD5_W];
            acc_reg_ff <= MGMT_ACCESS_RST[ACC_REG_INDEX_LSB +: FIELD5_W];
            acc_dir_ff <= MGMT_ACCESS_RST[ACC_DIR_BIT];
        end else if (acc_write) begin
            acc_phy_addr_ff <= wr_acc[ACC_PHY_ADDR_LSB +: FIELD5_W];
            acc_reg_ff <= wr_acc[ACC_REG_INDEX_LSB +: FIELD5_W];
            acc_dir_ff <= wr_acc[ACC_DIR_BIT];
        end
    end

    // Busy flag: set only by software, cleared only by completion
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= MGMT_IDLE;
        end else begin
            unique case (state_ff)
                MGMT_IDLE: begin
                    if (start_cycle) begin
                        state_ff <= MGMT_BUSY;
                    end
                end
                MGMT_BUSY: begin
                    if (i_phy_done) begin
                        state_ff <= MGMT_IDLE;
                    end
                end
            endcase
        end
    end

    // Data register: software while idle, PHY read result at completion
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mgmt_data_ff <= MGMT_DATA_RST;
        end else if (cycle_end & ~phy_cmd_ff.write) begin
            mgmt_data_ff <= i_phy_rdata;
        end else if (data_write) begin
            mgmt_data_ff <= wr_data[MGMT_DATA_W-1:0];
        end
    end

    // Request image latched at start so it stays steady for the whole cycle
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phy_cmd_ff <= '0;
        end else if (start_cycle) begin
            phy_cmd_ff.phy_addr <= wr_acc[ACC_PHY_ADDR_LSB +: FIELD5_W];
            phy_cmd_ff.reg_index <= wr_acc[ACC_REG_INDEX_LSB +: FIELD5_W];
            phy_cmd_ff.write <= wr_acc[ACC_DIR_BIT];
            phy_cmd_ff.wdata <= mgmt_data_ff;
        end
    end

    assign o_phy_req = phy_busy;
    assign o_phy_cmd = phy_cmd_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    property p_start_sets_busy;
        start_cycle |=> o_phy_req ##0 phy_busy;
    endproperty
    a_start_sets_busy: assert property (p_start_sets_busy) else $error("busy not set by start");

    property p_req_needs_start;
        $rose(o_phy_req) |-> $past(start_cycle);
    endproperty
    a_req_needs_start: assert property (p_req_needs_start) else $error("request without start");

    property p_busy_until_done;
        o_phy_req & ~i_phy_done |=> o_phy_req;
    endproperty
    a_busy_until_done: assert property (p_busy_until_done) else $error("busy dropped early");

    property p_done_clears;
        o_phy_req & i_phy_done |=> ~o_phy_req ##0 ~acc_image[ACC_BUSY_BIT];
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("busy not cleared");

    property p_read_loaded;
        cycle_end & ~o_phy_cmd.write |=> mgmt_data_ff == $past(i_phy_rdata);
    endproperty
    a_read_loaded: assert property (p_read_loaded) else $error("read result not loaded");

    property p_cmd_fields;
        start_cycle |=> o_phy_cmd.reg_index == $past(wr_acc[ACC_REG_INDEX_LSB +: FIELD5_W])
            && o_phy_cmd.write == $past(wr_acc[ACC_DIR_BIT]);
    endproperty
    a_cmd_fields: assert property (p_cmd_fields) else $error("request fields wrong");

    property p_write_data;
        start_cycle & wr_acc[ACC_DIR_BIT] |=> o_phy_cmd.wdata == $past(mgmt_data_ff);
    endproperty
    a_write_data: assert property (p_write_data) else $error("write data wrong");

    property p_hash_verdict;
        i_da_valid & is_group & ~pass_all_ff |=> o_filter_accept == $past(table_bit);
    endproperty
    a_hash_verdict: assert property (p_hash_verdict) else $error("hash verdict wrong");

    property p_index_ends;
        i_da_valid & is_group & ~pass_all_ff & (hash_idx == 6'h00 || hash_idx == 6'h3f)
            |=> o_filter_accept == $past(hash_idx == 6'h00 ? hash_low_ff[0] : hash_high_ff[31]);
    endproperty
    a_index_ends: assert property (p_index_ends) else $error("table end bits wrong");

    property p_pass_all;
        i_da_valid & is_group & pass_all_ff |=> o_filter_accept & o_filter_done;
    endproperty
    a_pass_all: assert property (p_pass_all) else $error("pass-all ignored");

    property p_reserved_zero;
        setup_ph & ~i_pwrite & (hit_acc | hit_data) |=> o_prdata[31:16] == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    c_phy_read: cover property (start_cycle & ~i_pwdata[ACC_DIR_BIT] ##[1:50] cycle_end);
    c_phy_write: cover property (start_cycle & i_pwdata[ACC_DIR_BIT] ##[1:50] cycle_end);
    c_hash_accept: cover property (i_da_valid & is_group & ~pass_all_ff & table_bit);
    c_slverr: cover property (setup_ph & ~hit_any);
endmodule : mac_hash_filter_phy_mgmt_regs

// File: shared/mac_filt_pkg.sv
// Purpose: Shared constants and types for the group hash filter and PHY management register bank.
// Assumes: 32-bit APB data, one aligned word per register, byte address = 4 x register index.
// Notes:   Every offset, field position, reset value and hash constant is named here once.
package mac_filt_pkg;
    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] HASH_HIGH_IDX = 8'h04;
    localparam logic [ADDR_W-1:0] HASH_LOW_IDX = 8'h05;
    localparam logic [ADDR_W-1:0] MGMT_ACCESS_IDX = 8'h06;
    localparam logic [ADDR_W-1:0] MGMT_DATA_IDX = 8'h07;
    localparam logic [ADDR_W-1:0] FILTER_CTRL_IDX = 8'h10;
    localparam logic [ADDR_W-1:0] HASH_HIGH_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] HASH_LOW_ADDR = 8'h14;
    localparam logic [ADDR_W-1:0] MGMT_ACCESS_ADDR = 8'h18;
    localparam logic [ADDR_W-1:0] MGMT_DATA_ADDR = 8'h1c;
    localparam logic [ADDR_W-1:0] FILTER_CTRL_ADDR = 8'h40;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ACC_PHY_ADDR_LSB = 11;
    localparam int ACC_REG_INDEX_LSB = 6;
    localparam int ACC_DIR_BIT = 1;
    localparam int ACC_BUSY_BIT = 0;
    localparam int FIELD5_W = 5;
    localparam int MGMT_DATA_W = 16;
    localparam int CTRL_PASS_ALL_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] HASH_HIGH_RST = 32'h0000_0000;
    localparam logic [31:0] HASH_LOW_RST = 32'h0000_0000;
    localparam logic [31:0] MGMT_ACCESS_RST = 32'h0000_0000;
    localparam logic [15:0] MGMT_DATA_RST = 16'h0000;
    localparam logic FILTER_CTRL_RST = 1'b0;

    // ------------------------------------------------------------
    // Hash and address constants
    // ------------------------------------------------------------
    localparam int DA_W = 48;
    localparam int HASH_IDX_W = 6;
    localparam int GROUP_BIT = 40;          // I/G bit: LSB of the first byte on the wire
    localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Management cycle request held toward the PHY register port
    typedef struct packed {
        logic [FIELD5_W-1:0] phy_addr;
        logic [FIELD5_W-1:0] reg_index;
        logic write;
        logic [MGMT_DATA_W-1:0] wdata;
    } phy_cmd_s;

    // Management engine states
    typedef enum logic {
        MGMT_IDLE,
        MGMT_BUSY
    } mgmt_state_e;
endpackage : mac_filt_pkg

// File: src/crc_hash_index.sv
// Purpose: Derives the six-bit multicast table index from a destination address.
// Assumes: Address byte [47:40] is the first byte on the wire; bits go LSB first.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module crc_hash_index
    import mac_filt_pkg::*;
#(
    parameter int IDX_W = mac_filt_pkg::HASH_IDX_W
) (
    input wire logic [mac_filt_pkg::DA_W-1:0] i_da,
    output logic [IDX_W-1:0] o_index
);
    import mac_filt_pkg::*;

    // ------------------------------------------------------------
    // CRC over the address in wire order
    // ------------------------------------------------------------
    // Serial CRC unrolled by the loop; 48 steps is small enough for one cycle at 100 MHz
    function automatic logic [31:0] crc_of(input logic [DA_W-1:0] da);
        logic [31:0] crc;
        logic fb;
        crc = CRC_INIT;
        for (int b = 0; b < DA_W / 8; b++) begin
            for (int k = 0; k < 8; k++) begin
                // Leftmost byte is most significant and goes first; LSB of each byte first
                fb = crc[31] ^ da[DA_W - 8 - 8 * b + k];
                crc = {crc[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
            end
        end
        return crc;
    endfunction : crc_of

    logic [31:0] crc_value; // CRC register after the last address bit

    // Top CRC bits form the index
    always_comb begin
        crc_value = crc_of(i_da);
        o_index = crc_value[31 -: IDX_W];
    end
endmodule : crc_hash_index

// File: verification/phy_port_model.sv
// Purpose: Behavioural PHY register port that answers management cycles.
// Assumes: One request at a time; i_wait sets how many cycles the answer takes.
// Notes:   Read data toggles outside the done cycle, so stale data never matches.
`timescale 1ns/1ps
module phy_port_model
    import mac_filt_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_req,
    input wire mac_filt_pkg::phy_cmd_s i_cmd,
    input wire logic [7:0] i_wait,
    output logic o_done,
    output logic [15:0] o_rdata
);
    import mac_filt_pkg::*;

    // ----------------------------------------
    // PHY registers
    // ----------------------------------------
    logic [15:0] mem [32]; // Known start pattern per index
    logic [4:0] last_phy_addr; // Address seen on the last answered cycle
    int cnt; // Cycles waited on the current request
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i] = {11'h0a5, 5'(i)};
        end
    end
    // Answer after i_wait cycles; a slow answer keeps the engine busy longer
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_done <= 1'b0;
            o_rdata <= 16'h0000;
            cnt <= 0;
        end else if (i_req && !o_done && cnt >= int'(i_wait)) begin
            o_done <= 1'b1;
            cnt <= 0;
            last_phy_addr <= i_cmd.phy_addr;
            o_rdata <= mem[i_cmd.reg_index];
            if (i_cmd.write) begin
                mem[i_cmd.reg_index] <= i_cmd.wdata;
            end
        end else begin
            o_done <= 1'b0;
            cnt <= (i_req && !o_done) ? cnt + 1 : 0;
            o_rdata <= ~o_rdata; // Not answering: the data lines keep moving
        end
    end
endmodule : phy_port_model

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the group hash filter and PHY management bank.
// Assumes: Zero-wait APB slave; PHY port played by phy_port_model.
// Notes:   Expected values come from bench-side model variables, never from the design.
`timescale 1ns/1ps
module tb_top;
    import mac_filt_pkg::*;
    // ----------------------------------------
    // Signals and bench model
    // ----------------------------------------
    logic i_sys_clk = 1'b0, i_nrst = 1'b0; // Clock and active-low reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, da_valid = 1'b0;
    logic [7:0] paddr = 8'h00, phy_wait = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h113e, rsink; // rsink takes read data nobody drives with
    logic pready, pslverr, f_done, f_group, f_accept, phy_req, phy_done;
    logic [47:0] da = 48'h0, a0, a63, cand; // Offered address and boundary hits
    logic [15:0] phy_rdata;
    phy_cmd_s phy_cmd;
    int failures = 0, n_checks = 0;
    logic [31:0] m_hh = 32'h0, m_hl = 32'h0, m_acc = 32'h0; // Expected register contents
    logic [15:0] m_data = 16'h0;
    logic m_pass = 1'b0;
    logic [7:0] addrs [6] = '{HASH_HIGH_ADDR, HASH_LOW_ADDR, MGMT_ACCESS_ADDR, MGMT_DATA_ADDR,
                              FILTER_CTRL_ADDR, 8'h20};
    always #5 i_sys_clk = ~i_sys_clk;
    mac_hash_filter_phy_mgmt_regs DUT (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_da_valid(da_valid), .i_da(da),
        .o_filter_done(f_done), .o_filter_group(f_group), .o_filter_accept(f_accept),
        .o_phy_req(phy_req), .o_phy_cmd(phy_cmd), .i_phy_done(phy_done), .i_phy_rdata(phy_rdata));
    phy_port_model PHY (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_req(phy_req), .i_cmd(phy_cmd),
        .i_wait(phy_wait), .o_done(phy_done), .o_rdata(phy_rdata));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Bench CRC: wire byte order, each byte LSB first, index from the top six bits
    function automatic logic [5:0] hash_of(logic [47:0] a);
        logic [31:0] c = 32'hffff_ffff;
        logic fb;
        for (int i = 0; i < 48; i++) begin
            fb = c[31] ^ a[40 - (i / 8) * 8 + i % 8];
            c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0);
        end
        return c[31:26];
    endfunction : hash_of
    function automatic logic [31:0] exp_of(logic [7:0] a);
        case (a)
            HASH_HIGH_ADDR: return m_hh;
            HASH_LOW_ADDR: return m_hl;
            MGMT_ACCESS_ADDR: return m_acc;
            MGMT_DATA_ADDR: return {16'h0, m_data};
            FILTER_CTRL_ADDR: return {31'h0, m_pass};
            default: return 32'h0; // Unmapped reads as zero
        endcase
    endfunction : exp_of
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; waits for pready, never assumes a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int t = 0;
        @(posedge i_sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) failures++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check(e, !(a inside {HASH_HIGH_ADDR, HASH_LOW_ADDR, MGMT_ACCESS_ADDR, MGMT_DATA_ADDR,
                             FILTER_CTRL_ADDR}));
        if (a == HASH_HIGH_ADDR) m_hh = d;
        if (a == HASH_LOW_ADDR) m_hl = d;
        if (a == MGMT_ACCESS_ADDR) m_acc = d & 32'h0000_ffc3;
        if (a == MGMT_DATA_ADDR) m_data = d[15:0];
        if (a == FILTER_CTRL_ADDR) m_pass = d[0];
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp_of(a));
        check(e, a == 8'h20);
    endtask : rd_chk
    // Offer one address and compare the filter verdict
    task automatic offer(input logic [47:0] a);
        logic [5:0] ix = hash_of(a);
        logic b = ix[5] ? m_hh[ix[4:0]] : m_hl[ix[4:0]]; // Top bit picks the word
        @(posedge i_sys_clk);
        da_valid <= 1'b1;
        da <= a;
        @(posedge i_sys_clk);
        da_valid <= 1'b0;
        da <= ~a;
        @(posedge i_sys_clk);
        check(f_done, 1'b1);
        check(f_group, a[40]);
        check(f_accept, a[40] & (m_pass | b));
    endtask : offer
    // One management cycle: start, poll busy, compare the outcome
    task automatic mgmt(input logic w, input logic [4:0] ix, input logic [15:0] exp_rd);
        logic [31:0] r;
        int t = 0;
        // Stale data must differ from the expected read result, so a missed load shows
        if (!w) wr(MGMT_DATA_ADDR, {16'h0, ~exp_rd});
        wr(MGMT_ACCESS_ADDR, {16'h0, 5'h01, ix, 4'h0, w, 1'b1});
        rd_chk(MGMT_ACCESS_ADDR, r);
        m_acc[0] = 1'b0;
        do begin
            apb(1'b0, MGMT_ACCESS_ADDR, 32'h0, r, cand[0]);
            t++;
        end while (r[0] !== 1'b0 && t < 100);
        check(r, m_acc);
        check(PHY.last_phy_addr, 5'h01);
        if (w) check(PHY.mem[ix], m_data);
        m_data = w ? m_data : exp_rd;
        rd_chk(MGMT_DATA_ADDR, r);
    endtask : mgmt
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        #500000;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        // Reset values, then random writes with reserved bits and an unmapped place
        foreach (addrs[i]) rd_chk(addrs[i], rsink);
        foreach (addrs[i]) wr(addrs[i], xs() & 32'hffff_fffe);
        foreach (addrs[i]) rd_chk(addrs[i], rsink);
        check(phy_req, 1'b0);
        // Boundary indices 0 and 63, searched in the bench
        for (int i = 0; i < 4000; i++) begin
            cand = {16'(xs()), xs()} | 48'h0100_0000_0000;
            if (hash_of(cand) == 6'd0) a0 = cand;
            if (hash_of(cand) == 6'd63) a63 = cand;
        end
        wr(HASH_HIGH_ADDR, 32'h8000_0000);
        wr(HASH_LOW_ADDR, 32'h0000_0001);
        wr(FILTER_CTRL_ADDR, 32'h0);
        for (int k = 0; k < 3; k++) begin
            offer(a0);
            offer(a63);
            wr(k == 0 ? HASH_HIGH_ADDR : FILTER_CTRL_ADDR, k == 0 ? 32'h7fff_ffff : 32'h1);
            if (k == 0) wr(HASH_LOW_ADDR, 32'hffff_fffe);
        end
        // Random tables, pass-all on and off, group and unicast addresses
        for (int i = 0; i < 48; i++) begin
            if (i % 12 == 0) begin
                wr(HASH_HIGH_ADDR, xs());
                wr(HASH_LOW_ADDR, xs());
                wr(FILTER_CTRL_ADDR, {31'h0, i[4] & i[3]});
            end
            offer({16'(xs()), xs()});
        end
        // PHY writes and reads, prompt and slow
        for (int k = 0; k < 4; k++) begin
            phy_wait <= 8'(k * 6);
            wr(MGMT_DATA_ADDR, xs() & 32'h0000_ffff);
            mgmt(1'b1, 5'(k), 16'h0);
            mgmt(1'b0, 5'(k), m_data);
            mgmt(1'b0, 5'(k + 16), {11'h0a5, 5'(k + 16)});
        end
        tally_and_finish();
    end
endmodule : tb_top
